// ==== lcd_split_consts.vh ====
// Register offsets, field positions and reset values for the screen address block
`ifndef LCD_SPLIT_CONSTS_VH
`define LCD_SPLIT_CONSTS_VH
// Register indices, byte address is four times the index
`define IDX_AC_DRIVE_RATE 8'h0b
`define IDX_S1_START_LO 8'h0c
`define IDX_S1_START_HI 8'h0d
`define IDX_S2_START_LO 8'h0f
`define IDX_S2_START_HI 8'h10
`define IDX_LINE_OFFSET 8'h12
`define IDX_S1_HEIGHT_LO 8'h13
`define IDX_S1_HEIGHT_HI 8'h14
`define IDX_CT_POINTER 8'h15
`define IDX_CT_DATA 8'h17
`define IDX_MODE_CTRL 8'h20
`define IDX_FETCH_STATUS 8'h21
// Field layout
`define RATE_W 6
`define POS_SEL_LO 4
`define POS_SEL_HI 5
`define POS_ROTATED 0
`define POS_PASSIVE 1
// Colour table select codes
`define SEL_AUTO 2'h0
`define SEL_RED 2'h1
`define SEL_GREEN 2'h2
`define SEL_BLUE 2'h3
// Reset values
`define RST_HEIGHT 10'h000
`define RST_MODE_CTRL 2'h2
`endif

// ==== colour_table.v ====
// Three sixteen-entry four-bit colour tables with one shared access port
`timescale 1ns/1ps
`default_nettype none
module colour_table (
    input wire clk_i,
    input wire en_i,
    input wire wr_i,
    input wire [1:0] table_i,
    input wire [3:0] index_i,
    input wire [3:0] wdata_i,
    output wire [3:0] rdata_o
);
    reg [3:0] mem_reg [0:47];
    wire [5:0] addr;

    // Flat address, table major
    assign addr = {table_i, index_i} - 6'h10;
    assign rdata_o = mem_reg[addr];

    // Table write
    always @(posedge clk_i) begin
        if (en_i && wr_i) begin
            mem_reg[addr] <= wdata_i;
        end
    end
endmodule // colour_table
`default_nettype wire

// ==== lcd_screen_address_split.v ====
// Frame address, split screen, AC drive and colour table pointer block
// Summary of operation
// - Zero rate toggles AC drive per frame
// - Nonzero rate toggles every rate+1 lines
// - AC drive rate only for passive panels
// - Start one is word or byte address
// - Start bit 15 used only when rotated
// - Start two addressed same way
// - Landscape adds word offset between lines
// - Nonzero offset gives virtual image window
// - Offset ignored in rotated orientation
// - Screen one height resets to zero
// - Lines 0..n screen one, rest two; code splits in landscape only
// - Three sixteen-entry four-bit colour tables
// - Pointer register picks table entry accessed
// - Data access advances table entry pointer
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "lcd_split_consts.vh"
module lcd_screen_address_split (
    input wire clk_i,
    input wire rst_n_i,
    input wire ce_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    output reg [31:0] prdata_o,
    output wire pready_o,
    output wire pslverr_o,
    input wire frame_pulse_i,
    input wire line_pulse_i,
    input wire line_words_done_i,
    input wire [9:0] vert_size_i,
    output reg ac_drive_toggle_o,
    output reg [15:0] fetch_addr_o,
    output reg screen_two_active_o,
    output reg [9:0] line_count_o
);
    // Control registers
    reg [5:0] ac_rate_reg;
    reg [15:0] s1_start_reg;
    reg [15:0] s2_start_reg;
    reg [7:0] line_offset_reg;
    reg [9:0] s1_height_reg;
    reg [1:0] ct_sel_reg;
    reg [3:0] ct_index_reg;
    reg [1:0] auto_phase_reg;
    reg [1:0] mode_reg;
    // Frame copies of the address settings
    reg [15:0] s1_live_reg;
    reg [15:0] s2_live_reg;
    reg [7:0] offset_live_reg;
    reg rotated_live_reg;
    // AC drive and fetch state
    reg [5:0] line_cnt_reg;
    reg [15:0] line_start_reg;
    // Pin synchronisers
    reg frame_s1_reg, frame_s2_reg, frame_d_reg;
    reg line_s1_reg, line_s2_reg, line_d_reg;
    reg done_s1_reg, done_s2_reg;
    wire frame_ev, line_ev, done_lv;
    wire rotated, passive;
    wire access, wr_acc, rd_acc, ct_data_acc;
    wire [7:0] idx;
    wire [1:0] ct_table;
    wire [3:0] ct_rdata;
    reg [15:0] next_line_start;
    reg [3:0] ct_index_next;
    reg [1:0] auto_phase_next;

    // Word index from byte address; unaligned addresses decode as unmapped
    // Addresses above the register window must not alias onto it
    function [7:0] reg_index;
        input [11:0] a;
        begin
            reg_index = (a[1:0] == 2'h0 && a[11:10] == 2'h0) ? a[9:2] : 8'hff;
        end
    endfunction

    // Mask start address to the bits in force for the orientation
    function [15:0] start_bits;
        input [15:0] s;
        input rot;
        begin
            start_bits = rot ? s : {1'b0, s[14:0]};
        end
    endfunction

    // True when a data access moves on to the next table entry
    function index_moves;
        input [1:0] sel;
        input [1:0] phase;
        begin
            index_moves = (sel != `SEL_AUTO) || (phase == 2'h2);
        end
    endfunction

    assign idx = reg_index(paddr_i);
    assign access = psel_i && penable_i && ce_i;
    assign wr_acc = access && pwrite_i;
    assign rd_acc = access && !pwrite_i;
    // Bus never waits and never errors
    assign pready_o = 1'b1;
    assign pslverr_o = 1'b0;
    assign rotated = mode_reg[`POS_ROTATED];
    assign passive = mode_reg[`POS_PASSIVE];
    assign ct_data_acc = access && (idx == `IDX_CT_DATA);
    // Auto mode walks red, green, blue at each index
    assign ct_table = (ct_sel_reg == `SEL_AUTO) ? auto_phase_reg + 2'h1 : ct_sel_reg;
    // Rising edges of the synchronised frame and line pins, one clock wide; done pin kept as a level
    assign frame_ev = frame_s2_reg && !frame_d_reg;
    assign line_ev = line_s2_reg && !line_d_reg;
    assign done_lv = done_s2_reg;

    // Pointer step after a table data access
    always @* begin
        if (index_moves(ct_sel_reg, auto_phase_reg)) begin
            ct_index_next = ct_index_reg + 4'h1;
            auto_phase_next = 2'h0;
        end else begin
            ct_index_next = ct_index_reg;
            auto_phase_next = auto_phase_reg + 2'h1;
        end
    end

    // Two-stage synchronisers and edge history
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            frame_s1_reg <= 1'b0;
            frame_s2_reg <= 1'b0;
            frame_d_reg <= 1'b0;
            line_s1_reg <= 1'b0;
            line_s2_reg <= 1'b0;
            line_d_reg <= 1'b0;
            done_s1_reg <= 1'b0;
            done_s2_reg <= 1'b0;
        end else if (ce_i) begin
            frame_s1_reg <= frame_pulse_i;
            frame_s2_reg <= frame_s1_reg;
            frame_d_reg <= frame_s2_reg;
            line_s1_reg <= line_pulse_i;
            line_s2_reg <= line_s1_reg;
            line_d_reg <= line_s2_reg;
            done_s1_reg <= line_words_done_i;
            done_s2_reg <= done_s1_reg;
        end
    end

    // Register writes and colour table pointer
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ac_rate_reg <= 6'h00;
            s1_start_reg <= 16'h0000;
            s2_start_reg <= 16'h0000;
            line_offset_reg <= 8'h00;
            s1_height_reg <= `RST_HEIGHT;
            ct_sel_reg <= 2'h0;
            ct_index_reg <= 4'h0;
            auto_phase_reg <= 2'h0;
            mode_reg <= `RST_MODE_CTRL;
        end else if (wr_acc) begin
            case (idx)
                `IDX_AC_DRIVE_RATE: ac_rate_reg <= pwdata_i[5:0];
                `IDX_S1_START_LO: s1_start_reg[7:0] <= pwdata_i[7:0];
                `IDX_S1_START_HI: s1_start_reg[15:8] <= pwdata_i[7:0];
                `IDX_S2_START_LO: s2_start_reg[7:0] <= pwdata_i[7:0];
                `IDX_S2_START_HI: s2_start_reg[15:8] <= pwdata_i[7:0];
                `IDX_LINE_OFFSET: line_offset_reg <= pwdata_i[7:0];
                `IDX_S1_HEIGHT_LO: s1_height_reg[7:0] <= pwdata_i[7:0];
                `IDX_S1_HEIGHT_HI: s1_height_reg[9:8] <= pwdata_i[1:0];
                `IDX_CT_POINTER: begin
                    ct_sel_reg <= pwdata_i[`POS_SEL_HI:`POS_SEL_LO];
                    ct_index_reg <= pwdata_i[3:0];
                    auto_phase_reg <= 2'h0; // Auto mode restarts at red
                end
                `IDX_CT_DATA: begin
                    ct_index_reg <= ct_index_next;
                    auto_phase_reg <= auto_phase_next;
                end
                `IDX_MODE_CTRL: mode_reg <= pwdata_i[1:0];
                default: ;
            endcase
        end else if (rd_acc && idx == `IDX_CT_DATA) begin
            // Table data read also steps the pointer
            ct_index_reg <= ct_index_next;
            auto_phase_reg <= auto_phase_next;
        end
    end

    // Colour table storage
    colour_table u_table (
        .clk_i(clk_i),
        .en_i(ct_data_acc),
        .wr_i(pwrite_i),
        .table_i(ct_table),
        .index_i(ct_index_reg),
        .wdata_i(pwdata_i[3:0]),
        .rdata_o(ct_rdata)
    );

    // Read data mux, registered in the setup cycle
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prdata_o <= 32'h00000000;
        end else if (ce_i && psel_i && !penable_i) begin
            case (idx)
                `IDX_AC_DRIVE_RATE: prdata_o <= {26'h0, ac_rate_reg};
                `IDX_S1_START_LO: prdata_o <= {24'h0, s1_start_reg[7:0]};
                `IDX_S1_START_HI: prdata_o <= {24'h0, s1_start_reg[15:8]};
                `IDX_S2_START_LO: prdata_o <= {24'h0, s2_start_reg[7:0]};
                `IDX_S2_START_HI: prdata_o <= {24'h0, s2_start_reg[15:8]};
                `IDX_LINE_OFFSET: prdata_o <= {24'h0, line_offset_reg};
                `IDX_S1_HEIGHT_LO: prdata_o <= {24'h0, s1_height_reg[7:0]};
                `IDX_S1_HEIGHT_HI: prdata_o <= {30'h0, s1_height_reg[9:8]};
                `IDX_CT_POINTER: prdata_o <= {26'h0, ct_sel_reg, ct_index_reg};
                `IDX_CT_DATA: prdata_o <= {28'h0, ct_rdata};
                `IDX_MODE_CTRL: prdata_o <= {30'h0, mode_reg};
                `IDX_FETCH_STATUS: prdata_o <= {5'h0, screen_two_active_o,
                    line_count_o, fetch_addr_o};
                default: prdata_o <= 32'h00000000;
            endcase
        end
    end

    // AC drive toggle, passive panels only
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ac_drive_toggle_o <= 1'b0;
            line_cnt_reg <= 6'h00;
        end else if (ce_i && passive) begin
            if (ac_rate_reg == 6'h00) begin
                line_cnt_reg <= 6'h00;
                if (frame_ev) begin
                    ac_drive_toggle_o <= !ac_drive_toggle_o;
                end
            end else if (line_ev) begin
                if (line_cnt_reg >= ac_rate_reg) begin
                    line_cnt_reg <= 6'h00;
                    ac_drive_toggle_o <= !ac_drive_toggle_o;
                end else begin
                    line_cnt_reg <= line_cnt_reg + 6'h01;
                end
            end
        end
    end

    // Start of next line: landscape skips the offset words
    always @* begin
        if (rotated_live_reg) begin
            next_line_start = line_start_reg;
        end else begin
            next_line_start = {1'b0, fetch_addr_o[14:0] + {7'h00, offset_live_reg}};
        end
    end

    // Frame and line address sequencing with split screen
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_live_reg <= 16'h0000;
            s2_live_reg <= 16'h0000;
            offset_live_reg <= 8'h00;
            rotated_live_reg <= 1'b0;
            fetch_addr_o <= 16'h0000;
            line_start_reg <= 16'h0000;
            line_count_o <= 10'h000;
            screen_two_active_o <= 1'b0;
        end else if (ce_i) begin
            if (frame_ev) begin
                s1_live_reg <= s1_start_reg;
                s2_live_reg <= s2_start_reg;
                offset_live_reg <= line_offset_reg;
                rotated_live_reg <= rotated;
                fetch_addr_o <= start_bits(s1_start_reg, rotated);
                line_start_reg <= start_bits(s1_start_reg, rotated);
                line_count_o <= 10'h000;
                screen_two_active_o <= 1'b0;
            end else if (line_ev) begin
                line_count_o <= line_count_o + 10'h001;
                // Split only in landscape and only below the panel height
                if (!rotated_live_reg && line_count_o == s1_height_reg
                    && s1_height_reg < vert_size_i) begin
                    screen_two_active_o <= 1'b1;
                    fetch_addr_o <= start_bits(s2_live_reg, 1'b0);
                    line_start_reg <= start_bits(s2_live_reg, 1'b0);
                end else begin
                    fetch_addr_o <= next_line_start;
                    line_start_reg <= next_line_start;
                end
            end else if (done_lv && !frame_ev) begin
                fetch_addr_o <= fetch_addr_o; // Held until the line pulse
            end
        end
    end
endmodule // lcd_screen_address_split
`default_nettype wire

// ==== lcd_split_monitor.sv ====
// Port checker for the screen address and split block
`timescale 1ns/1ps
`default_nettype none
module lcd_split_monitor (
    input wire clk_i,
    input wire rst_n_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] prdata_o,
    input wire pready_o,
    input wire pslverr_o,
    input wire frame_pulse_i,
    input wire line_pulse_i,
    input wire ac_drive_toggle_o,
    input wire [15:0] fetch_addr_o,
    input wire screen_two_active_o,
    input wire [9:0] line_count_o
);
    reg [1:0] pin_reg;
    reg [5:0] rise_reg;
    // Recent pin rises, events land a few clocks later
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_reg <= 2'h0;
            rise_reg <= 6'h00;
        end else begin
            pin_reg <= {frame_pulse_i, line_pulse_i};
            rise_reg <= {rise_reg[4:0], |({frame_pulse_i, line_pulse_i} & ~pin_reg)};
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    chk_unmapped_zero: assert property ((psel_i && !penable_i && !pwrite_i && paddr_i == 12'h3fc)
        |=> prdata_o == 32'h0) else $error("unmapped read not zero");
    chk_no_wait: assert property (psel_i && penable_i |-> pready_o && !pslverr_o)
        else $error("access stalled or errored");
    chk_frame_restart: assert property ($rose(frame_pulse_i) |-> ##[1:5] line_count_o == 10'h000)
        else $error("frame did not restart line count");
    chk_count_step: assert property ($changed(line_count_o) |-> line_count_o == 10'h000
        || line_count_o == $past(line_count_o) + 10'h001) else $error("line count jump");
    chk_two_not_first: assert property (screen_two_active_o |-> line_count_o != 10'h000)
        else $error("second screen on line zero");
    chk_two_drop: assert property ($fell(screen_two_active_o) |-> line_count_o == 10'h000)
        else $error("second screen left mid frame");
    chk_ac_cause: assert property ($changed(ac_drive_toggle_o) |-> |rise_reg)
        else $error("drive toggled without event");
    chk_ac_single: assert property ($changed(ac_drive_toggle_o) |=> $stable(ac_drive_toggle_o))
        else $error("drive toggled twice");
    chk_fetch_cause: assert property ($changed(fetch_addr_o) |-> |rise_reg)
        else $error("fetch address moved without event");
endmodule // lcd_split_monitor
bind lcd_screen_address_split lcd_split_monitor i_mon (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .frame_pulse_i(frame_pulse_i), .line_pulse_i(line_pulse_i),
    .ac_drive_toggle_o(ac_drive_toggle_o), .fetch_addr_o(fetch_addr_o),
    .screen_two_active_o(screen_two_active_o), .line_count_o(line_count_o));
`default_nettype wire

// ==== panel_timing_model.sv ====
// Panel timing source: a frame pulse, then one line pulse per panel line
`timescale 1ns/1ps
`default_nettype none
module panel_timing_model (
    input wire clk_i,
    input wire [9:0] vert_size_i,
    output logic frame_o,
    output logic line_o,
    output logic done_o
);
    integer k;
    // Quiet pins at time zero
    initial begin
        frame_o = 1'b0;
        line_o = 1'b0;
        done_o = 1'b0;
    end
    // Vertical size plus one lines after each frame pulse
    always begin
        for (k = 0; k <= vert_size_i + 1; k = k + 1) begin
            @(posedge clk_i);
            frame_o <= (k == 0);
            line_o <= (k != 0);
            done_o <= 1'b0;
            repeat (2) @(posedge clk_i);
            frame_o <= 1'b0;
            line_o <= 1'b0;
            done_o <= (k != 0);
            repeat (5) @(posedge clk_i);
        end
    end
endmodule // panel_timing_model
`default_nettype wire

// ==== tb.sv ====
// Testbench for the screen address and split block
`timescale 1ns/1ps
`default_nettype none
`include "lcd_split_consts.vh"
module tb;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, frm, lin, done, ac, two;
    logic [15:0] fetch;
    logic [9:0] cnt, vert = 10'h005;
    logic [15:0] exp_l [1:4] = '{16'h0125, 16'h0127, 16'h0400, 16'h0402};
    logic [7:0] rates [0:3] = '{8'h00, 8'h01, 8'h02, 8'h01};
    logic [31:0] tog_exp [0:3] = '{32'h1, 32'h3, 32'h2, 32'h0};
    integer miscompares = 0, tests_run = 0, toggles = 0, i;
    always #4 clk_i = ~clk_i;
    lcd_screen_address_split i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
        .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .frame_pulse_i(frm),
        .line_pulse_i(lin), .line_words_done_i(done), .vert_size_i(vert),
        .ac_drive_toggle_o(ac), .fetch_addr_o(fetch), .screen_two_active_o(two),
        .line_count_o(cnt));
    panel_timing_model i_panel (.clk_i(clk_i), .vert_size_i(vert), .frame_o(frm),
        .line_o(lin), .done_o(done));
    // Counts toggles of the drive output
    always @(ac) toggles = toggles + 1;
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One APB transfer, held until pready
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] v);
        @(posedge clk_i);
        psel <= 1'b1;
        pwr <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h0, v};
        @(posedge clk_i);
        pen <= 1'b1;
        @(posedge clk_i);
        while (pready !== 1'b1) @(posedge clk_i);
        rd = prdata;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] v);
        bus(1'b1, idx, v);
    endtask
    task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 8'h00);
        check(rd, exp);
    endtask
    // Waits a frame or line pin pulse plus the sync lag
    // Level wait so a pulse rising as a bus call ends is not missed
    task automatic evt(input logic f);
        if (f) wait (frm === 1'b1);
        else wait (lin === 1'b1);
        repeat (5) @(posedge clk_i);
        #1;
    endtask
    task automatic wrap_up;
        if (miscompares == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (20000) @(posedge clk_i);
        miscompares = miscompares + 1;
        wrap_up();
    end
    initial begin
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rdc(`IDX_S1_HEIGHT_LO, 32'h0);
        rdc(`IDX_S1_HEIGHT_HI, 32'h0);
        rdc(8'hff, 32'h0);
        // Landscape split after line 2
        wr(`IDX_S1_START_LO, 8'h23);
        wr(`IDX_S1_START_HI, 8'h81);
        wr(`IDX_S2_START_LO, 8'h00);
        wr(`IDX_S2_START_HI, 8'h04);
        wr(`IDX_LINE_OFFSET, 8'h02);
        wr(`IDX_S1_HEIGHT_LO, 8'h02);
        rdc(`IDX_S1_START_HI, 32'h81);
        evt(1'b1);
        check({cnt, two, fetch}, 32'h0123);
        for (i = 1; i < 5; i = i + 1) begin
            evt(1'b0);
            check({cnt, two, fetch}, {i[9:0], i > 2, exp_l[i]});
        end
        // Rotated: full start address, no offset, no split
        wr(`IDX_S1_HEIGHT_HI, 8'h03);
        wr(`IDX_S1_HEIGHT_LO, 8'hff);
        wr(`IDX_MODE_CTRL, 8'h03);
        evt(1'b1);
        check(fetch, 32'h8123);
        wr(`IDX_S1_START_LO, 8'h55);
        evt(1'b0);
        check({two, fetch}, 32'h8123);
        evt(1'b1);
        check(fetch, 32'h8155);
        // Drive toggles per frame, for rates 0, 1 and 2 and both panel kinds
        for (i = 0; i < 4; i = i + 1) begin
            wr(`IDX_MODE_CTRL, {6'h00, i < 3, 1'b0});
            wr(`IDX_AC_DRIVE_RATE, rates[i]);
            @(posedge frm);
            toggles = 0;
            @(posedge frm);
            check(toggles, tog_exp[i]);
        end
        // Landscape, height equal to vertical size: no split; new offset waits a frame
        wr(`IDX_S1_HEIGHT_HI, 8'h00);
        wr(`IDX_S1_HEIGHT_LO, 8'h05);
        evt(1'b1);
        wr(`IDX_LINE_OFFSET, 8'h04);
        for (i = 1; i < 7; i = i + 1) begin
            evt(1'b0);
            check({two, fetch}, {1'b0, 16'h0155 + i[15:0] * 16'h0002});
        end
        evt(1'b1);
        evt(1'b0);
        check(fetch, 32'h0159);
        // Colour table pointer and data
        wr(`IDX_CT_POINTER, 8'h13);
        wr(`IDX_CT_DATA, 8'h0a);
        wr(`IDX_CT_DATA, 8'h0b);
        rdc(`IDX_CT_POINTER, 32'h15);
        wr(`IDX_CT_POINTER, 8'h03);
        for (i = 0; i < 3; i = i + 1) wr(`IDX_CT_DATA, i[7:0] + 8'h01);
        rdc(`IDX_CT_POINTER, 32'h04);
        wr(`IDX_CT_POINTER, 8'h14);
        rdc(`IDX_CT_DATA, 32'h0b);
        wr(`IDX_CT_POINTER, 8'h33);
        rdc(`IDX_CT_DATA, 32'h03);
        wrap_up();
    end
endmodule // tb
`default_nettype wire
